/* File: design/adcs_sequencer.sv */
// Purpose: conversion sequencer of a 10-bit successive-approximation converter
// Assumes: AHB-Lite slave, single word transfers, comparator decision as a pin
// Notes: reads take one wait state, writes none; answers are always OKAY
`timescale 1ns/10ps

// What this block does
// - enable starts conversion or trigger wait
// - ten bits resolved, then result stored
// - interrupt only after required conversion count
// - mode write aborts, discards, restarts conversion
// - active flag set on trigger, cleared after
// - trigger source chosen by second mode field
// - self-start repeats passes while enabled
// - timer mode uses one selected timer event
// - external mode uses selected pin edge
// - pin edge during conversion restarts it
// - buffer and scan bits pick operation
// - select mode converts chosen input only
// - single slot maps input, interrupts each
// - four slots per group, interrupt after fourth
// - self-start four-slot restarts group after interrupt
// - scan ascends from zero to chosen input
// - result high ten bits, low six zero
// - timer event during conversion restarts it
module adcs_sequencer
   import adcs_pkg::*;
#(
   parameter int STEP_CYCLES = BIT_STEP_CYCLES,
   parameter int TIMERS = TIMER_TRIG_N
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // trigger sources
   input wire logic [TIMERS-1:0] timer_trigger,
   input wire logic external_trigger_pin,
   // analog side
   input wire logic comparator_decision,
   output logic [RES_BITS-1:0] dac_trial_code,
   output logic [SLOT_W-1:0] analog_input_selected,
   // status
   output logic conversion_active_flag,
   output logic conversion_end_irq
);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [SLOT_W-1:0] clamp_ch(input logic [SLOT_W-1:0] ch);
      clamp_ch = (ch > LAST_CH) ? LAST_CH : ch;
   endfunction : clamp_ch

   // upper group of inputs shares slots four to seven, the rest zero to three
   function automatic logic [SLOT_W-1:0] slot_of(input logic four, input logic [SLOT_W-1:0] ch,
                                                 input logic [1:0] num);
      if (!four) begin
         slot_of = ch;
      end else if (ch >= UPPER_GROUP_LO && ch <= UPPER_GROUP_HI) begin
         slot_of = UPPER_GROUP_LO + {2'b00, num};
      end else begin
         slot_of = {2'b00, num};
      end
   endfunction : slot_of

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   localparam int PINS = 2;
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] sync1, sync2, sync3, pin_level;
   assign pin_raw = {external_trigger_pin, comparator_decision};

   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_sync
         // a level counts only once the second and third stage agree
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               pin_level[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  pin_level[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------
   // registers and bus slave
   // ----------------------------------------------------------
   logic [7:0] mode_reg_first, mode_reg_second, channel_select_reg, timer_trigger_select_reg;
   logic rd_stage, wr_stage, mode_written;
   logic [ADDR_W-1:0] dp_addr;
   logic [RES_BITS-1:0] mem_rd_data;
   logic [SLOT_W-1:0] mem_rd_addr;
   logic accept;
   adcs_state_type state;

   assign accept = hsel && htrans[1] && hready;
   assign mem_rd_addr = SLOT_W'((haddr[ADDR_W-1:0] - RESULT_BASE_OFS) >> 2);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_stage <= 1'b0;
         wr_stage <= 1'b0;
         dp_addr <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= READ_ZERO;
      end else begin
         wr_stage <= accept && hwrite;
         rd_stage <= accept && !hwrite;
         if (accept) begin
            dp_addr <= haddr[ADDR_W-1:0];
         end
         // one wait state lets the result memory answer from its register
         if (accept && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_stage) begin
            hreadyout <= 1'b1;
            if (dp_addr == MODE_FIRST_OFS) begin
               hrdata <= {24'h00_0000, mode_reg_first[7], state == ST_CONV, mode_reg_first[5:0]};
            end else if (dp_addr == MODE_SECOND_OFS) begin
               hrdata <= {24'h00_0000, mode_reg_second};
            end else if (dp_addr == CHANNEL_SEL_OFS) begin
               hrdata <= {24'h00_0000, channel_select_reg};
            end else if (dp_addr == TIMER_TRIG_SEL_OFS) begin
               hrdata <= {24'h00_0000, timer_trigger_select_reg};
            end else if (dp_addr >= RESULT_BASE_OFS && dp_addr <= RESULT_LAST_OFS &&
                         dp_addr[1:0] == 2'b00) begin
               hrdata <= {16'h0000, mem_rd_data, {LSB_PAD{1'b0}}};
            end else begin
               hrdata <= READ_ZERO;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg_first <= MODE_RESET;
         mode_reg_second <= MODE_RESET;
         channel_select_reg <= MODE_RESET;
         timer_trigger_select_reg <= MODE_RESET;
         mode_written <= 1'b0;
      end else begin
         mode_written <= 1'b0;
         if (wr_stage) begin
            if (dp_addr == MODE_FIRST_OFS) begin
               mode_reg_first <= hwdata[7:0] & MODE_FIRST_WMASK;
               mode_written <= 1'b1;
            end else if (dp_addr == MODE_SECOND_OFS) begin
               mode_reg_second <= hwdata[7:0];
               mode_written <= 1'b1;
            end else if (dp_addr == CHANNEL_SEL_OFS) begin
               channel_select_reg <= hwdata[7:0];
               mode_written <= 1'b1;
            end else if (dp_addr == TIMER_TRIG_SEL_OFS) begin
               timer_trigger_select_reg <= hwdata[7:0];
            end
         end
      end
   end

   // ----------------------------------------------------------
   // mode decode and triggers
   // ----------------------------------------------------------
   logic enable, scan, four, self_mode, timer_mode, ext_mode;
   logic [SLOT_W-1:0] sel_ch, first_ch;
   logic ext_prev, ext_edge, timer_hit, trig_hit;
   logic [1:0] edge_sel;

   assign enable = mode_reg_first[ENABLE_BIT];
   assign scan = mode_reg_first[SCAN_BIT];
   assign four = !scan && mode_reg_first[BUFFER_BIT];
   assign self_mode = mode_reg_second[TRIG_HI_BIT:TRIG_LO_BIT] == TRIG_SELF;
   assign timer_mode = mode_reg_second[TRIG_HI_BIT:TRIG_LO_BIT] == TRIG_TIMER;
   assign ext_mode = mode_reg_second[TRIG_HI_BIT:TRIG_LO_BIT] == TRIG_EXTERNAL;
   assign edge_sel = mode_reg_second[EDGE_HI_BIT:EDGE_LO_BIT];
   assign sel_ch = clamp_ch(channel_select_reg[SLOT_W-1:0]);
   assign first_ch = scan ? '0 : sel_ch;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= pin_level[1];
      end
   end

   assign ext_edge = (edge_sel == EDGE_FALLING) ? (ext_prev && !pin_level[1]) :
                     (edge_sel == EDGE_RISING) ? (!ext_prev && pin_level[1]) :
                     (ext_prev != pin_level[1]);
   assign timer_hit = (int'(timer_trigger_select_reg[TIMER_SEL_W-1:0]) < TIMERS) &&
                      timer_trigger[timer_trigger_select_reg[TIMER_SEL_W-1:0]];
   assign trig_hit = (timer_mode && timer_hit) || (ext_mode && ext_edge);

   // ----------------------------------------------------------
   // successive approximation sequencer
   // ----------------------------------------------------------
   localparam int STEP_W = $clog2(STEP_CYCLES + 1);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
   logic [RES_BITS-1:0] sar, bit_mask, sar_resolved;
   logic [STEP_W-1:0] step_cnt;
   logic [1:0] conv_num;
   logic [SLOT_W-1:0] scan_ch;
   logic step_end, conv_done, pass_last, cmp_level;

   assign step_end = (state == ST_CONV) && (step_cnt == STEP_LAST);
   // agreed stages count at once: waiting on pin_level would hand each step
   // the decision made on the previous trial code
   assign cmp_level = (sync2[0] == sync3[0]) ? sync3[0] : pin_level[0];
   assign sar_resolved = cmp_level ? sar : (sar & ~bit_mask);
   // store only after the last bit
   assign conv_done = step_end && bit_mask[0] && !mode_written && !trig_hit;
   assign pass_last = scan ? (scan_ch >= clamp_ch(channel_select_reg[SLOT_W-1:0])) :
                      four ? (conv_num == LAST_OF_FOUR) : 1'b1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         sar <= '0;
         bit_mask <= '0;
         step_cnt <= '0;
         conv_num <= '0;
         scan_ch <= '0;
         analog_input_selected <= '0;
      end else if (mode_written) begin
         // abort and restart from the beginning
         conv_num <= '0;
         scan_ch <= '0;
         sar <= SAR_TOP;
         bit_mask <= SAR_TOP;
         step_cnt <= '0;
         analog_input_selected <= first_ch;
         if (!enable) begin
            state <= ST_IDLE;
         end else if (self_mode || state == ST_CONV) begin
            state <= ST_CONV;
         end else begin
            state <= ST_WAIT;
         end
      end else if (trig_hit && state != ST_IDLE) begin
         // trigger starts or restarts the current conversion
         state <= ST_CONV;
         sar <= SAR_TOP;
         bit_mask <= SAR_TOP;
         step_cnt <= '0;
         analog_input_selected <= scan ? scan_ch : sel_ch;
      end else if (state == ST_CONV) begin
         step_cnt <= step_end ? '0 : step_cnt + 1'b1;
         if (step_end && !bit_mask[0]) begin
            sar <= sar_resolved | (bit_mask >> 1);
            bit_mask <= bit_mask >> 1;
         end else if (conv_done) begin
            sar <= SAR_TOP;
            bit_mask <= SAR_TOP;
            if (pass_last) begin
               conv_num <= '0;
               scan_ch <= '0;
               analog_input_selected <= first_ch;
               // self-start begins the next pass, others wait
               state <= self_mode ? ST_CONV : ST_WAIT;
            end else if (scan) begin
               scan_ch <= scan_ch + 1'b1;
               analog_input_selected <= scan_ch + 1'b1;
            end else begin
               // four successive results, one trigger each outside self-start
               conv_num <= conv_num + 1'b1;
               state <= self_mode ? ST_CONV : ST_WAIT;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conversion_end_irq <= 1'b0;
      end else begin
         conversion_end_irq <= conv_done && pass_last;
      end
   end

   // state code bit one is the converting state
   assign conversion_active_flag = state[1];
   assign dac_trial_code = sar;

   // ----------------------------------------------------------
   // result slots
   // ----------------------------------------------------------
   adcs_result_mem #(
      .DEPTH(NUM_CH),
      .WIDTH(RES_BITS)
   ) u_result_mem (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(conv_done),
      .wr_addr(slot_of(four, analog_input_selected, conv_num)),
      .wr_data(sar_resolved),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data)
   );

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   localparam int CONV_LEN = RES_BITS * STEP_CYCLES - 1;
   logic [15:0] conv_age;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_age <= '0;
      end else if (state == ST_CONV && bit_mask == SAR_TOP && step_cnt == '0) begin
         conv_age <= 16'h0001;
      end else begin
         conv_age <= conv_age + 1'b1;
      end
   end

   bit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done |-> int'(conv_age) == CONV_LEN)
      else $error("result stored before all bits resolved");
   self_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_written && enable && self_mode |=> conversion_active_flag && bit_mask == SAR_TOP)
      else $error("self-start did not begin conversion");
   trig_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_written && enable && !self_mode && state != ST_CONV |=> state == ST_WAIT)
      else $error("trigger mode did not wait");
   restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_written && enable && state == ST_CONV |-> !conv_done ##1
      (state == ST_CONV && step_cnt == '0 && conv_num == '0))
      else $error("mode write did not restart conversion");
   active_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state == ST_WAIT && trig_hit && !mode_written |=> conversion_active_flag)
      else $error("trigger did not raise active flag");
   disable_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_written && !enable |=> !conversion_active_flag ##1 !conv_done)
      else $error("clearing enable did not stop");
   single_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done && !scan && !four |=> conversion_end_irq)
      else $error("single slot conversion without interrupt");
   four_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done && four && conv_num != LAST_OF_FOUR |=> !conversion_end_irq)
      else $error("four slot interrupt before fourth result");
   scan_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done && scan && !pass_last |=> analog_input_selected == $past(scan_ch) + 1'b1)
      else $error("scan did not advance to next input");
   ext_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state == ST_CONV && ext_mode && ext_edge && !mode_written |=> bit_mask == SAR_TOP)
      else $error("pin edge did not restart conversion");
endmodule : adcs_sequencer

/* File: design/adcs_pkg.sv */
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes: register offsets are byte addresses of aligned words
package adcs_pkg;
   // ----------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // least settle time of one comparator decision
   localparam int BIT_STEP_NS = 40;
   localparam int BIT_STEP_CYCLES = (BIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------
   // converter shape
   // ----------------------------------------------------------
   localparam int RES_BITS = 10;
   localparam int NUM_CH = 10;
   localparam int SLOT_W = 4;
   localparam int LSB_PAD = 6;
   localparam logic [SLOT_W-1:0] LAST_CH = 4'h9;
   localparam logic [SLOT_W-1:0] UPPER_GROUP_LO = 4'h4;
   localparam logic [SLOT_W-1:0] UPPER_GROUP_HI = 4'h7;
   localparam logic [1:0] LAST_OF_FOUR = 2'h3;
   localparam logic [RES_BITS-1:0] SAR_TOP = 10'h200;
   localparam int TIMER_TRIG_N = 8;
   localparam int TIMER_SEL_W = 3;

   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] MODE_FIRST_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] MODE_SECOND_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] CHANNEL_SEL_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] TIMER_TRIG_SEL_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] RESULT_BASE_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] RESULT_LAST_OFS = 8'h64;

   // ----------------------------------------------------------
   // fields
   // ----------------------------------------------------------
   localparam int ENABLE_BIT = 7;
   localparam int ACTIVE_BIT = 6;
   localparam int SCAN_BIT = 5;
   localparam int BUFFER_BIT = 4;
   localparam logic [7:0] MODE_FIRST_WMASK = 8'hb0;
   localparam int TRIG_HI_BIT = 5;
   localparam int TRIG_LO_BIT = 2;
   localparam int EDGE_HI_BIT = 1;
   localparam int EDGE_LO_BIT = 0;
   localparam logic [3:0] TRIG_SELF = 4'h0;
   localparam logic [3:0] TRIG_TIMER = 4'h4;
   localparam logic [3:0] TRIG_EXTERNAL = 4'h8;
   localparam logic [1:0] EDGE_FALLING = 2'h0;
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_CONV = 2'b10
   } adcs_state_type;
endpackage : adcs_pkg

/* File: design/adcs_result_mem.sv */
// Purpose: result slots of the converter, one word per slot
// Assumes: one write port from the sequencer, one read port to the bus
// Notes: read data is registered, so it trails the read address by one edge
`timescale 1ns/10ps
module adcs_result_mem
   import adcs_pkg::*;
#(
   parameter int DEPTH = NUM_CH,
   parameter int WIDTH = RES_BITS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // write port
   input wire logic wr_en,
   input wire logic [SLOT_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic [SLOT_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data <= '0;
      end else if (int'(rd_addr) < DEPTH) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end
endmodule : adcs_result_mem

/* File: testbench/adcs_partner.sv */
// Purpose: far side of the sequencer: timer events, trigger pin, comparator
// Assumes: timer events are one hclk cycle wide; the pin is a plain level
// Notes: the comparator is ideal, so every full pass resolves target_code exactly
`timescale 1ns/10ps
module adcs_partner
   import adcs_pkg::*;
#(
   parameter int TIMERS = TIMER_TRIG_N
) (
   // clock
   input wire logic hclk,
   // analog side
   input wire logic [RES_BITS-1:0] dac_trial_code,
   input wire logic [RES_BITS-1:0] target_code,
   output logic comparator_decision,
   // trigger sources
   output logic [TIMERS-1:0] timer_trigger,
   output logic external_trigger_pin
);
   assign comparator_decision = (target_code >= dac_trial_code);

   initial begin
      timer_trigger = '0;
      external_trigger_pin = 1'b0;
   end

   task automatic pulse_timer(input int idx);
      @(posedge hclk);
      timer_trigger[idx] <= 1'b1;
      @(posedge hclk);
      timer_trigger <= '0;
   endtask : pulse_timer

   task automatic set_pin(input logic level);
      @(posedge hclk);
      external_trigger_pin <= level;
   endtask : set_pin
endmodule : adcs_partner

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the conversion sequencer over AHB-Lite
// Assumes: hready fed back from hreadyout; bit steps of 4 cycles, the package default
// Notes: expected results follow from target_code, never from the design
`timescale 1ns/10ps
module tb
   import adcs_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, comparator_decision, external_trigger_pin;
   logic conversion_active_flag, conversion_end_irq;
   logic [TIMER_TRIG_N-1:0] timer_trigger;
   logic [RES_BITS-1:0] dac_trial_code;
   logic [RES_BITS-1:0] target_code = 10'h2a5;
   logic [SLOT_W-1:0] analog_input_selected;
   logic [31:0] rd;
   int n_mismatch = 0;
   int cmp_count = 0;
   int irq_count = 0;
   int base;

   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (conversion_end_irq === 1'b1) irq_count <= irq_count + 1;
   end

   adcs_sequencer #(.STEP_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .timer_trigger(timer_trigger),
      .external_trigger_pin(external_trigger_pin),
      .comparator_decision(comparator_decision), .dac_trial_code(dac_trial_code),
      .analog_input_selected(analog_input_selected),
      .conversion_active_flag(conversion_active_flag),
      .conversion_end_irq(conversion_end_irq));

   adcs_partner partner (.hclk(hclk), .dac_trial_code(dac_trial_code),
      .target_code(target_code), .comparator_decision(comparator_decision),
      .timer_trigger(timer_trigger), .external_trigger_pin(external_trigger_pin));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one single-word transfer; address phase held until hready, then data phase
   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, ofs};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task automatic wait_irqs(input int n);
      for (int k = 0; k < 3000 && irq_count < n; k++) @(posedge hclk);
   endtask : wait_irqs

   function automatic logic [31:0] res(input logic [RES_BITS-1:0] v);
      return {16'h0000, v, 6'h00};
   endfunction : res

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      #300_000;
      n_mismatch++;
      complete_run;
   end

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values and an unmapped place
      bus(1'b0, MODE_FIRST_OFS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b1, 8'h30, 32'h0000_00ff);
      bus(1'b0, 8'h30, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      $display("test reset done");
      // self-start, one slot, input 2
      bus(1'b1, CHANNEL_SEL_OFS, 32'h0000_0002);
      bus(1'b1, MODE_SECOND_OFS, 32'h0000_0000);
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_0080);
      wait_irqs(1);
      check(irq_count, 1);
      bus(1'b0, RESULT_BASE_OFS + 8'h08, 32'h0000_0000);
      check(rd, res(target_code));
      check(hresp, 1'b0);
      // a mode write mid-conversion throws the running result away
      bus(1'b1, CHANNEL_SEL_OFS, 32'h0000_0002);
      base = irq_count;
      repeat (38) @(posedge hclk);
      check(irq_count, base);
      wait_irqs(2);
      check(irq_count, 2);
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_0000);
      repeat (100) @(posedge hclk);
      base = irq_count;
      check(conversion_active_flag, 1'b0);
      repeat (100) @(posedge hclk);
      check(irq_count, base);
      $display("test self start done");
      // timer trigger, four slots, input 5 lands in slots 4..7
      target_code = 10'h155;
      bus(1'b1, CHANNEL_SEL_OFS, 32'h0000_0005);
      bus(1'b1, MODE_SECOND_OFS, 32'h0000_0010);
      bus(1'b1, TIMER_TRIG_SEL_OFS, 32'h0000_0003);
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_0090);
      repeat (60) @(posedge hclk);
      check(conversion_active_flag, 1'b0);
      partner.pulse_timer(2);
      repeat (60) @(posedge hclk);
      check(conversion_active_flag, 1'b0);
      for (int i = 0; i < 4; i++) begin
         partner.pulse_timer(3);
         repeat (20) @(posedge hclk);
         check(conversion_active_flag, 1'b1);
         check(analog_input_selected, 4'h5);
         if (i == 0) begin
            // a second event mid-conversion starts it over
            partner.pulse_timer(3);
            repeat (30) @(posedge hclk);
            check(conversion_active_flag, 1'b1);
         end
         repeat (40) @(posedge hclk);
         check(conversion_active_flag, 1'b0);
         check(dac_trial_code, SAR_TOP);
         check(irq_count, base + ((i == 3) ? 1 : 0));
      end
      for (int k = 4; k < 8; k++) begin
         bus(1'b0, RESULT_BASE_OFS + 8'(4 * k), 32'h0000_0000);
         check(rd, res(target_code));
      end
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_0000);
      $display("test timer four slots done");
      // external rising edge, scan up to input 3
      target_code = 10'h3c1;
      base = irq_count;
      bus(1'b1, CHANNEL_SEL_OFS, 32'h0000_0003);
      bus(1'b1, MODE_SECOND_OFS, 32'h0000_0021);
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_00a0);
      bus(1'b0, MODE_FIRST_OFS, 32'h0000_0000);
      check(rd, 32'h0000_00a0);
      partner.set_pin(1'b1);
      // a second rising edge inside the first conversion starts it over
      repeat (10) @(posedge hclk);
      partner.set_pin(1'b0);
      repeat (10) @(posedge hclk);
      partner.set_pin(1'b1);
      repeat (150) @(posedge hclk);
      check(irq_count, base);
      wait_irqs(base + 1);
      check(irq_count, base + 1);
      for (int k = 0; k < 5; k++) begin
         bus(1'b0, RESULT_BASE_OFS + 8'(4 * k), 32'h0000_0000);
         check(rd, res((k < 4) ? target_code : 10'h155));
      end
      check(conversion_active_flag, 1'b0);
      $display("test external scan done");
      // self-start four slots: one interrupt per group of four
      target_code = 10'h0f0;
      base = irq_count;
      bus(1'b1, MODE_FIRST_OFS, 32'h0000_0090);
      bus(1'b1, MODE_SECOND_OFS, 32'h0000_0000);
      wait_irqs(base + 1);
      repeat (100) @(posedge hclk);
      check(irq_count, base + 1);
      wait_irqs(base + 2);
      check(irq_count, base + 2);
      bus(1'b0, RESULT_BASE_OFS + 8'h0c, 32'h0000_0000);
      check(rd, res(target_code));
      $display("test self start four slots done");
      complete_run;
   end
endmodule : tb
